// file: logic/swm_defines.svh
// What this block does
// - Programmable inputs: battery side reads high as closed, ground side inverse.
// - Two fixed battery inputs report closed when comparator shows above reference.
// - Six fixed ground inputs report open when above reference, closed below.
// - Reset clears the command registers (pin synchronisers load ones) and enters sleep until a valid command.
// - Sleep command or hardware reset enters sleep; all currents off, inputs floated.
// - Only run, tri-state or metallic commands leave sleep.
// - Normal mode keeps currents on and interrupts on any switch change.
// - Normal mode: sustain current, wetting current on closure, off after 20 ms.
// - Polling samples periodically, stays while all open, closure interrupts and goes normal.
// - During polling off periods all source and sink currents are disabled.
// - Polling with timer interrupts on closure (going normal) or on wake timer expiry.
// - Wake timer expiry with all open interrupts and stays in timer polling.
// - Run word sets programmable input polarity: one battery, zero ground.
// - Floated inputs have comparators disabled and report zero status.
// - Full-duplex 16-bit serial slave words, most significant bit first.
// - Each transfer returns switch status captured at chip-select falling edge.
// - Sixteen clocks per transfer; after deselect input ignored, output floated.
// - Returned status reflects the previous command or hardware reset.
// - Bits 16..13 decode sleep, run, tri-state, metallic, test; others only clear test mode.
// - Run word fields: state select, off code, wake code, polarity; bit 7 unused.
// - Tri-state word fields: ground, programmable, battery enable flags.
// - Metallic word fields: ground, programmable, battery metallic flags.
// - Float register resets to zero; run and metallic must be rewritten by controller.
// - Select fall latches status; rise releases interrupt and applies command.
// - State select 01 normal, 10 polling, 11 polling with timer, 00 also normal.
// - Float bit zero keeps input disabled, one enables; floated after leaving sleep.
// - Metallic bit one enables wetting pulse, zero disables it.
`ifndef SWM_DEFINES_SVH
`define SWM_DEFINES_SVH

`define SWM_CMD_SLEEP 4'h0
`define SWM_CMD_RUN 4'h1
`define SWM_CMD_FLOAT 4'h3
`define SWM_CMD_METAL 4'h5
`define SWM_TEST_BIT 15
`define SWM_WORD_BITS 16
`define SWM_CLK_HZ 20000000
`define SWM_WET_MS 20
`define SWM_TDET_US 4800
`define SWM_TWAKE_US 2800
`define SWM_ON_US 5100
`define SWM_FLOAT_RST 12'h000

`endif

// file: logic/swm_pkg.sv
package swm_pkg;
	// Gray coded along sleep -> normal -> poll -> timer poll
	typedef enum logic [1:0] {
		SWM_SLEEP = 2'b00,
		SWM_NORMAL = 2'b01,
		SWM_POLL = 2'b11,
		SWM_POLL_TMR = 2'b10
	} swm_mode_t;

	typedef enum logic [1:0] {
		SWM_PH_ON = 2'b00,
		SWM_PH_OFF = 2'b01
	} swm_phase_t;

	typedef struct packed {
		logic [5:0] ground;
		logic [3:0] prog;
		logic [1:0] battery;
	} swm_inputs_t;

	typedef struct packed {
		logic [1:0] operating_state_sel;
		logic [2:0] off_interval_code;
		logic unused;
		logic [1:0] wake_interval_code;
		logic [3:0] programmable_input_polarity;
	} swm_run_t;
endpackage : swm_pkg

// file: logic/swm_spi_shift.sv
`timescale 1ns/1ps
`include "swm_defines.svh"
// Serial shifter: synchronises pins, finds edges, shifts 16-bit words
module swm_spi_shift
	import swm_pkg::*;
#(
	parameter int WIDTH = `SWM_WORD_BITS
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic [WIDTH-1:0] tx_word,
	output logic miso_o,
	output logic miso_oe,
	output logic cs_fall,
	output logic cs_rise,
	output logic [WIDTH-1:0] rx_word_q,
	output logic [$clog2(WIDTH+1)-1:0] bit_cnt_q
);
	logic [2:0] s1_q, s2_q, s3_q;
	logic [WIDTH-1:0] tx_q;
	logic sck_rise, sck_fall, sel;

	// --------------------------------
	// Pin synchronisers
	// --------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= 3'h7;
			s2_q <= 3'h7;
			s3_q <= 3'h7;
		end else begin
			s1_q <= {sclk, cs_n, mosi};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign sel = ~s2_q[1];
	assign cs_fall = s3_q[1] & ~s2_q[1];
	assign cs_rise = ~s3_q[1] & s2_q[1];
	assign sck_rise = sel & s2_q[2] & ~s3_q[2];
	assign sck_fall = sel & ~s2_q[2] & s3_q[2];

	// Input sampled on rising clock, MSB first; ignored when deselected
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_word_q <= '0;
			bit_cnt_q <= '0;
		end else if (cs_fall) begin
			bit_cnt_q <= '0;
		end else if (sck_rise) begin
			rx_word_q <= {rx_word_q[WIDTH-2:0], s2_q[0]};
			if (bit_cnt_q != WIDTH[$clog2(WIDTH+1)-1:0])
				bit_cnt_q <= bit_cnt_q + 1'b1;
		end
	end

	// Output loaded at select fall, advanced on falling clock
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			tx_q <= '0;
		else if (cs_fall)
			tx_q <= tx_word;
		else if (sck_fall)
			tx_q <= {tx_q[WIDTH-2:0], 1'b0};
	end

	assign miso_o = tx_q[WIDTH-1];
	assign miso_oe = sel;
endmodule : swm_spi_shift

// file: logic/swm_core.sv
`timescale 1ns/1ps
`include "swm_defines.svh"
// Switch monitor command interpreter and mode control
module swm_core
	import swm_pkg::*;
#(
	parameter int CLK_HZ = `SWM_CLK_HZ,
	parameter int WET_MS = `SWM_WET_MS,
	parameter int TDET_US = `SWM_TDET_US,
	parameter int TWAKE_US = `SWM_TWAKE_US,
	parameter int ON_US = `SWM_ON_US,
	// Cycles per 100 us tick; shorten in simulation
	parameter int TICK_CYC = CLK_HZ / 10000
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe,
	output logic irq_n_o,
	output logic irq_n_oe,
	input wire logic [11:0] above_ref,
	output logic [11:0] comp_en_q,
	output logic [11:0] sustain_en_q,
	output logic [11:0] wetting_en_q,
	output logic [3:0] sink_mode_q,
	output swm_mode_t mode_q,
	output logic test_mode_q
);
	// One tick = 100 us at default rate
	localparam int TICK_US = 100;
	localparam int WET_TK = WET_MS * 1000 / TICK_US;
	localparam int ON_TK = (ON_US + TICK_US - 1) / TICK_US;
	localparam int DET_TK = (TDET_US + TICK_US - 1) / TICK_US;
	localparam int WDET_TK = (TWAKE_US + TICK_US - 1) / TICK_US;
	localparam int TW = 20;

	// ----------------------------------------
	// Duration tables from code (ticks)
	// ----------------------------------------
	function automatic logic [TW-1:0] off_ticks(input logic [2:0] c);
		int m;
		m = 5 + 8 * int'(c);
		return TW'(m * DET_TK);
	endfunction : off_ticks

	function automatic logic [TW-1:0] wake_ticks(input logic [1:0] c);
		int m;
		m = (512 >> c) + 1;
		return TW'(m * WDET_TK);
	endfunction : wake_ticks

	logic [TW-1:0] tick_cnt_q;
	logic tick;
	logic cs_fall, cs_rise;
	logic [15:0] rx_word;
	logic [4:0] bit_cnt;
	logic [15:0] tx_word;
	logic [1:0] a1_q [12];
	logic [11:0] above_s;
	logic [11:0] closed;
	logic [11:0] prev_closed_q;
	swm_run_t run_q;
	swm_inputs_t float_q, metal_q;
	logic irq_q;
	swm_phase_t phase_q;
	logic [TW-1:0] phase_cnt_q, wake_cnt_q;
	logic [TW-1:0] wet_cnt_q [12];
	logic currents_on, any_closed, changed;

	swm_spi_shift #(.WIDTH(16)) u_shift (
		.clk(clk),
		.arst_n(arst_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.mosi(mosi),
		.tx_word(tx_word),
		.miso_o(miso_o),
		.miso_oe(miso_oe),
		.cs_fall(cs_fall),
		.cs_rise(cs_rise),
		.rx_word_q(rx_word),
		.bit_cnt_q(bit_cnt)
	);

	// ----------------------------------------
	// Timebase divider
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			tick_cnt_q <= '0;
		else if (tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 1'b1;
	end
	assign tick = (tick_cnt_q == TW'(TICK_CYC - 1));

	// Comparator outputs are asynchronous to clk
	genvar g;
	generate
		for (g = 0; g < 12; g++) begin : g_sync
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n)
					a1_q[g] <= 2'h0;
				else
					a1_q[g] <= {a1_q[g][0], above_ref[g]};
			end
			assign above_s[g] = a1_q[g][1];
		end
	endgenerate

	// ----------------------------------------
	// Polarity interpretation, disabled inputs read zero
	// ----------------------------------------
	always_comb begin
		closed[11:6] = ~above_s[11:6];
		closed[5:2] = above_s[5:2] ^ ~run_q.programmable_input_polarity;
		closed[1:0] = above_s[1:0];
		closed = closed & comp_en_q;
	end
	assign any_closed = |closed;
	assign changed = (closed != prev_closed_q);

	// ----------------------------------------
	// Command registers, applied on select rise
	// ----------------------------------------
	logic cmd_ok;
	assign cmd_ok = cs_rise && (bit_cnt == 5'd16);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_q <= '0;
			float_q <= `SWM_FLOAT_RST;
			metal_q <= '0;
			test_mode_q <= 1'b0;
		end else if (cmd_ok) begin
			if (rx_word[`SWM_TEST_BIT])
				test_mode_q <= 1'b1;
			else begin
				test_mode_q <= 1'b0;
				case (rx_word[15:12])
					`SWM_CMD_SLEEP: float_q <= `SWM_FLOAT_RST;
					`SWM_CMD_RUN: run_q <= rx_word[11:0];
					`SWM_CMD_FLOAT: float_q <= rx_word[11:0];
					`SWM_CMD_METAL: metal_q <= rx_word[11:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Operating mode machine
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= SWM_SLEEP;
		end else if (cmd_ok && !rx_word[`SWM_TEST_BIT]) begin
			case (rx_word[15:12])
				`SWM_CMD_SLEEP: mode_q <= SWM_SLEEP;
				`SWM_CMD_RUN: begin
					case (rx_word[11:10])
						2'b01: mode_q <= SWM_NORMAL;
						2'b10: mode_q <= SWM_POLL;
						2'b11: mode_q <= SWM_POLL_TMR;
						default: mode_q <= SWM_NORMAL;
					endcase
				end
				`SWM_CMD_FLOAT, `SWM_CMD_METAL: begin
					if (mode_q == SWM_SLEEP)
						mode_q <= SWM_NORMAL;
				end
				default: ;
			endcase
		end else begin
			case (mode_q)
				SWM_POLL, SWM_POLL_TMR: begin
					if (phase_q == SWM_PH_ON && any_closed)
						mode_q <= SWM_NORMAL;
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Polling on/off phase and wake timer
	// ----------------------------------------
	logic polling;
	assign polling = (mode_q == SWM_POLL) || (mode_q == SWM_POLL_TMR);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= SWM_PH_ON;
			phase_cnt_q <= '0;
		end else if (!polling) begin
			phase_q <= SWM_PH_ON;
			phase_cnt_q <= '0;
		end else if (tick) begin
			case (phase_q)
				SWM_PH_ON: begin
					if (phase_cnt_q >= TW'(ON_TK - 1)) begin
						phase_q <= SWM_PH_OFF;
						phase_cnt_q <= '0;
					end else
						phase_cnt_q <= phase_cnt_q + 1'b1;
				end
				SWM_PH_OFF: begin
					if (phase_cnt_q >= off_ticks(run_q.off_interval_code)
						- 1'b1) begin
						phase_q <= SWM_PH_ON;
						phase_cnt_q <= '0;
					end else
						phase_cnt_q <= phase_cnt_q + 1'b1;
				end
				default: phase_q <= SWM_PH_ON;
			endcase
		end
	end

	logic wake_exp;
	assign wake_exp = (mode_q == SWM_POLL_TMR) && tick &&
		(wake_cnt_q >= wake_ticks(run_q.wake_interval_code) - 1'b1);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			wake_cnt_q <= '0;
		else if (mode_q != SWM_POLL_TMR || wake_exp)
			wake_cnt_q <= '0;
		else if (tick)
			wake_cnt_q <= wake_cnt_q + 1'b1;
	end

	// ----------------------------------------
	// Current and comparator enables
	// ----------------------------------------
	assign currents_on = (mode_q == SWM_NORMAL) ||
		(polling && phase_q == SWM_PH_ON);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			comp_en_q <= '0;
			sustain_en_q <= '0;
			sink_mode_q <= '0;
		end else begin
			comp_en_q <= (mode_q == SWM_SLEEP) ? 12'h000 : float_q;
			sustain_en_q <= currents_on ? float_q : 12'h000;
			sink_mode_q <= run_q.programmable_input_polarity;
		end
	end

	// Wetting pulse per input; the timer bounds dissipation on closure
	generate
		for (g = 0; g < 12; g++) begin : g_wet
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					wet_cnt_q[g] <= '0;
					wetting_en_q[g] <= 1'b0;
				end else if (!currents_on || !metal_q[g] || !float_q[g]
					|| !closed[g]) begin
					wet_cnt_q[g] <= '0;
					wetting_en_q[g] <= 1'b0;
				end else if (wet_cnt_q[g] < TW'(WET_TK)) begin
					wetting_en_q[g] <= 1'b1;
					if (tick)
						wet_cnt_q[g] <= wet_cnt_q[g] + 1'b1;
				end else
					wetting_en_q[g] <= 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------
	// Interrupt: set wins over the select-rise clear
	// ----------------------------------------
	logic irq_set;
	assign irq_set = ((mode_q == SWM_NORMAL) && changed) ||
		(polling && phase_q == SWM_PH_ON && any_closed) ||
		wake_exp;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_q <= 1'b0;
			prev_closed_q <= '0;
		end else begin
			prev_closed_q <= closed;
			if (irq_set)
				irq_q <= 1'b1;
			else if (cs_rise)
				irq_q <= 1'b0;
		end
	end

	assign irq_n_o = 1'b0;
	assign irq_n_oe = irq_q;

	// ----------------------------------------
	// Response word, captured by the shifter at select fall
	// ----------------------------------------
	// A separate snapshot register would be one cycle late
	assign tx_word = {1'b0, irq_q, mode_q, closed};
endmodule : swm_core

// file: tb/swm_core_sva.sv
`timescale 1ns/1ps
// Port-level checks on the switch monitor core
module swm_core_sva
	import swm_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic irq_n_o,
	input wire logic irq_n_oe,
	input wire logic [11:0] above_ref,
	input wire logic [11:0] comp_en_q,
	input wire logic [11:0] sustain_en_q,
	input wire logic [11:0] wetting_en_q,
	input wire logic [3:0] sink_mode_q,
	input wire swm_mode_t mode_q,
	input wire logic test_mode_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic cs_d_q;
	logic [3:0] since_q;
	// Cycles since select rose; config must only move just after it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_d_q <= 1'b1;
			since_q <= 4'hf;
		end else begin
			cs_d_q <= cs_n;
			if (cs_n && !cs_d_q)
				since_q <= 4'h0;
			else if (since_q != 4'hf)
				since_q <= since_q + 4'h1;
		end
	end
	// ----------------
	// Assertions
	// ----------------
	AST_MISO_OFF: assert property (cs_n [*5] |-> !miso_oe)
		else $error("serial output driven while deselected");
	AST_MISO_ON: assert property (
		$fell(cs_n) |-> ##4 (miso_oe || cs_n))
		else $error("serial output not enabled after select");
	AST_SLEEP_QUIET: assert property (
		(mode_q == SWM_SLEEP) [*3] |->
		(comp_en_q | sustain_en_q | wetting_en_q) == 12'h000)
		else $error("currents or comparators on while asleep");
	AST_SLEEP_HOLD: assert property (
		(mode_q == SWM_SLEEP && cs_n) [*8] |=> mode_q == SWM_SLEEP)
		else $error("left sleep without a command");
	AST_IRQ_CLR: assert property (
		$rose(cs_n) |-> ##[1:6] !irq_n_oe)
		else $error("interrupt not released after select");
	AST_SLEEP_NOIRQ: assert property (
		(mode_q == SWM_SLEEP) [*3] |-> !irq_n_oe && !irq_n_o)
		else $error("interrupt driven while asleep");
	AST_RST_FLOAT: assert property (
		$rose(arst_n) |-> (comp_en_q == 12'h000) [*8])
		else $error("inputs enabled out of reset");
	AST_CFG_TIMING: assert property (
		!$stable(sink_mode_q) || $rose(test_mode_q) |-> since_q < 4'h8)
		else $error("config changed away from select rise");
endmodule : swm_core_sva

bind swm_core swm_core_sva u_sva (.clk, .arst_n, .sclk, .cs_n, .mosi,
	.miso_o, .miso_oe, .irq_n_o, .irq_n_oe, .above_ref, .comp_en_q,
	.sustain_en_q, .wetting_en_q, .sink_mode_q, .mode_q, .test_mode_q);

// file: tb/swm_mcu_model.sv
`timescale 1ns/1ps
// Controller model: master of select, link clock and data in
module swm_mcu_model (
	input wire logic clk,
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe
);
	// Link clock stands low outside frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask : hold
	// One frame, 400 ns link clock; n below 16 gives a short frame
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] r);
		int i;
		r = 16'h0000;
		cs_n = 1'b0;
		hold(8);
		for (i = 0; i < n; i++) begin
			mosi = w[15 - i];
			hold(4);
			sclk = 1'b1;
			r = {r[14:0], miso_oe ? miso_o : 1'bx};
			hold(4);
			sclk = 1'b0;
		end
		hold(4);
		cs_n = 1'b1;
		mosi = ~mosi; // Released line must not look like held data
		hold(8);
	endtask : xfer
endmodule : swm_mcu_model

// file: tb/test_swm_core.sv
`timescale 1ns/1ps
// Bench: command words through the controller model, pins checked
module test_swm_core;
	import swm_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic sclk, cs_n, mosi, miso_o, miso_oe, irq_n_o, irq_n_oe, test_mode_q;
	logic [11:0] above_ref = 12'hffc;
	logic [11:0] comp_en_q, sustain_en_q, wetting_en_q;
	logic [3:0] sink_mode_q;
	swm_mode_t mode_q;
	logic [15:0] r;
	logic [3:0] bad[3] = '{4'h2, 4'h4, 4'h7};
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int k;
	always #25 clk = ~clk;
	// Short tick so the long timers fit the run
	swm_core #(.TICK_CYC(4)) DUT (.clk, .arst_n, .sclk, .cs_n, .mosi,
		.miso_o, .miso_oe, .irq_n_o, .irq_n_oe, .above_ref, .comp_en_q,
		.sustain_en_q, .wetting_en_q, .sink_mode_q, .mode_q, .test_mode_q);
	swm_mcu_model u_mcu (.clk, .sclk, .cs_n, .mosi, .miso_o, .miso_oe);
	// ----------------
	// Helpers
	// ----------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Closed reads 1; floated inputs read 0
	function automatic logic [11:0] exp_st(input logic [11:0] a, en,
		input logic [3:0] pol);
		return {~a[11:6], a[5:2] ~^ pol, a[1:0]} & en;
	endfunction : exp_st
	task automatic end_sim();
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// Run needs about 20000 cycles; well above that means a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			fails++;
			end_sim();
		end
	end
	// ----------------
	// Sequence
	// ----------------
	initial begin
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		foreach (bad[i]) begin
			u_mcu.xfer({bad[i], 12'hfff}, 16, r);
			chk("resp", r, 16'h0000);
			chk("mode", mode_q, SWM_SLEEP);
		end
		u_mcu.xfer(16'h3fff, 8, r);
		chk("mode", mode_q, SWM_SLEEP);
		u_mcu.xfer(16'h3fff, 16, r);
		chk("mode", mode_q, SWM_NORMAL);
		chk("comp", comp_en_q, 12'hfff);
		u_mcu.xfer(16'h5fff, 16, r);
		chk("resp", r, 16'h1000);
		u_mcu.xfer(16'h1405, 16, r);
		chk("pol", sink_mode_q, 4'h5);
		for (k = 0; k < 100 && irq_n_oe !== 1'b1; k++) @(negedge clk);
		chk("irq", irq_n_oe, 1'b1);
		u_mcu.xfer(16'h2000, 16, r);
		chk("resp", r, {4'h5, exp_st(above_ref, 12'hfff, 4'h5)});
		chk("irq", irq_n_oe, 1'b0);
		// Wetting pulse on a fresh metallic closure, then timed off
		above_ref[11] = 1'b0;
		for (k = 0; k < 100 && wetting_en_q[11] !== 1'b1; k++) @(negedge clk);
		chk("wet", wetting_en_q[11], 1'b1);
		for (k = 0; k < 1000 && wetting_en_q[11] !== 1'b0; k++) @(negedge clk);
		chk("wet time", k > 760 && k < 840, 1'b1);
		u_mcu.xfer(16'h8000, 16, r);
		chk("test", {test_mode_q, mode_q}, {1'b1, SWM_NORMAL});
		// Polling: currents off between samples, closure goes normal
		above_ref = 12'hffc;
		u_mcu.xfer(16'h1800, 16, r);
		for (k = 0; k < 1500 && sustain_en_q !== 12'h000; k++) @(negedge clk);
		chk("off", sustain_en_q, 12'h000);
		repeat (1500) @(negedge clk);
		chk("mode", mode_q, SWM_POLL);
		above_ref[0] = 1'b1;
		for (k = 0; k < 5000 && {irq_n_oe, mode_q} !== {1'b1, SWM_NORMAL}; k++)
			@(negedge clk);
		chk("poll", {irq_n_oe, mode_q}, {1'b1, SWM_NORMAL});
		above_ref[0] = 1'b0;
		u_mcu.xfer(16'h1c60, 16, r);
		for (k = 0; k < 20000 && irq_n_oe !== 1'b1; k++) @(negedge clk);
		chk("wake", {irq_n_oe, mode_q}, {1'b1, SWM_POLL_TMR});
		u_mcu.xfer(16'h0000, 16, r);
		chk("quiet", {mode_q, comp_en_q, sustain_en_q}, 26'h0);
		u_mcu.xfer(16'h2000, 16, r);
		chk("resp", r, 16'h0000);
		end_sim();
	end
endmodule : test_swm_core
